// ===== pkg/psrfw_pkg.sv
package psrfw_pkg;
  // instruction field positions
  localparam int unsigned COND_HI = 31;
  localparam int unsigned COND_LO = 28;
  localparam int unsigned DEST_SEL_BIT = 22;
  localparam int unsigned IMM_SEL_BIT = 25;
  localparam int unsigned ROT_HI = 11;
  localparam int unsigned ROT_LO = 8;
  localparam int unsigned SRC_IDX_HI = 3;
  localparam int unsigned IMM8_HI = 7;
  localparam int unsigned FIX_A_HI = 27;
  localparam int unsigned FIX_A_LO = 26;
  localparam int unsigned FIX_B_HI = 24;
  localparam int unsigned FIX_B_LO = 23;
  localparam int unsigned FIX_C_HI = 21;
  localparam int unsigned FIX_C_LO = 12;
  localparam int unsigned REG_ZERO_LO = 4;

  // fixed opcode fields
  localparam logic [1:0] OPC_27_26 = 2'h0;
  localparam logic [1:0] OPC_24_23 = 2'h2;
  localparam logic [9:0] OPC_21_12 = 10'h14F; // 101001111 as printed, zero-extended to ten bits
  localparam logic [7:0] REG_FORM_ZERO = 8'h00;

  // condition flag field of a status word (N Z C V)
  localparam int unsigned FLAG_HI = 31;
  localparam int unsigned FLAG_LO = 28;
  localparam logic [31:0] FLAG_MASK = 32'hF000_0000;

  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [3:0] COND_RST = 4'h0;
  localparam logic [3:0] IDX_RST = 4'h0;

  typedef enum logic [1:0] {
    PSRFW_IDLE = 2'b00,
    PSRFW_FETCH = 2'b01,
    PSRFW_WRITE = 2'b11
  } psrfw_state_t;
endpackage

// ===== core/psrfw_decoder.sv
// Behaviour
// - top four bits are the condition code
// - bit 22 selects current or saved register
// - bit 25 selects register or immediate operand
// - recognise only the fixed opcode pattern
// - register form: index bits 3:0, 11:4 zero
// - immediate form: unsigned eight-bit constant base
// - write touches only the condition flag bits
`timescale 1ns/1ps
module psrfw_decoder (
  input wire logic i_core_clk, // 125 MHz core clock
  input wire logic i_srst, // synchronous reset, active high
  input wire logic i_instr_valid, // instruction word offered
  output logic o_instr_ready, // decoder can take a word
  input wire logic [31:0] i_instr, // instruction word
  output logic o_src_reg_rd, // one-cycle register read request
  output logic [3:0] o_source_reg_index, // register to read
  input wire logic [31:0] i_src_reg_data, // register value, valid in the cycle the request stands
  input wire logic [31:0] i_current_status_reg, // current status word
  input wire logic [31:0] i_saved_status_reg, // saved status word of active mode
  output logic o_wr_en, // one-cycle status write strobe
  output logic o_dest_status_select, // 0 current, 1 saved
  output logic [3:0] o_cond, // condition code governing the write
  output logic [31:0] o_wr_data, // full status word to write
  output logic [31:0] o_wr_mask, // bits changed by the write
  output logic o_unrecognised // one-cycle pulse, word not this form
);
  import psrfw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the instruction layout is fixed by the processor; these checks only
  // catch a package edit that the narrow fields below could not carry
  if (COND_HI - COND_LO != 3) begin : g_cond_width
    $error("condition field must be four bits wide");
  end
  if (ROT_HI - ROT_LO != 3) begin : g_rot_width
    $error("rotate field must be four bits wide");
  end
  if (ROT_LO != IMM8_HI + 1) begin : g_imm_split
    $error("rotate field must sit just above the constant");
  end
  if (SRC_IDX_HI != 3) begin : g_idx_width
    $error("source register index must be four bits wide");
  end
  if (FIX_C_HI - FIX_C_LO != 9) begin : g_fixed_width
    $error("fixed opcode field must be ten bits wide");
  end
  if (DEST_SEL_BIT != FIX_C_HI + 1 || FIX_B_LO != DEST_SEL_BIT + 1) begin : g_dest_place
    $error("destination select must sit between the fixed fields");
  end
  if (IMM_SEL_BIT != FIX_B_HI + 1 || FIX_A_LO != IMM_SEL_BIT + 1) begin : g_imm_place
    $error("operand kind bit must sit between the fixed fields");
  end
  // the write mask is its own constant so the output needs no arithmetic;
  // it must still agree with the flag field position
  if (FLAG_MASK != (((32'h0000_0001 << (FLAG_HI - FLAG_LO + 1)) - 32'h0000_0001) << FLAG_LO)) begin : g_flag_mask
    $error("flag mask does not match the flag field");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // rotate right by an even amount, as the rotator does; the amount is
  // doubled by a wire shift, so only even rotations can be expressed
  function automatic logic [31:0] rot_imm(input logic [7:0] imm, input logic [3:0] rot);
    logic [31:0] w;
    logic [4:0] sh;
    w = {24'h00_0000, imm};
    sh = {rot, 1'b0};
    // a zero amount shifts the left half out by a full word, leaving w
    return (w >> sh) | (w << (6'h20 - {1'b0, sh}));
  endfunction

  // merge flag field of source into a status word
  // non-flag bits come from the old word, so a write cannot disturb them
  function automatic logic [31:0] merge_flags(input logic [31:0] old_w, input logic [31:0] src);
    return (old_w & ~FLAG_MASK) | (src & FLAG_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode of the offered word

  logic fix_a_ok;
  logic fix_b_ok;
  logic fix_c_ok;
  logic opc_ok;
  logic reg_ok;
  logic is_imm;
  logic recognised;
  logic take_any;
  logic take_rec;
  logic take_bad;
  assign is_imm = i_instr[IMM_SEL_BIT];
  // each fixed field compared on its own; a stray bit anywhere turns the word away
  assign fix_a_ok = (i_instr[FIX_A_HI:FIX_A_LO] == OPC_27_26);
  assign fix_b_ok = (i_instr[FIX_B_HI:FIX_B_LO] == OPC_24_23);
  assign fix_c_ok = (i_instr[FIX_C_HI:FIX_C_LO] == OPC_21_12);
  assign opc_ok = fix_a_ok && fix_b_ok && fix_c_ok;
  // register form demands zeros in 11:4; immediate form uses them
  assign reg_ok = is_imm || (i_instr[ROT_HI:REG_ZERO_LO] == REG_FORM_ZERO);
  assign recognised = opc_ok && reg_ok;

  // a word is taken only while idle; unrecognised words are taken too,
  // flagged and dropped, so the fetch stage never stalls on them
  assign take_any = o_instr_ready && i_instr_valid;
  assign take_rec = take_any && recognised;
  assign take_bad = take_any && !recognised;

  ////////////////////////////////////////////////////////////////////////
  // state

  // sequencer state and the captured fields of the word in flight
  psrfw_state_t state_ff;
  psrfw_state_t nxt_state;
  logic dest_ff;
  logic [3:0] cond_ff;
  logic [3:0] idx_ff;
  logic [31:0] src_ff;

  // one word at a time; a register operand costs one extra read cycle
  assign o_instr_ready = (state_ff == PSRFW_IDLE);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // idle: ready is high, a recognised word moves on at once
      PSRFW_IDLE: begin
        if (take_rec) begin
          nxt_state = is_imm ? PSRFW_WRITE : PSRFW_FETCH;
        end
      end
      // fetch: the register read is in flight, data lands at its end
      PSRFW_FETCH: nxt_state = PSRFW_WRITE;
      // write: merge and strobe are launched, ready returns next
      PSRFW_WRITE: nxt_state = PSRFW_IDLE;
      default: nxt_state = PSRFW_IDLE;
    endcase
  end

  // state register; reset leaves the decoder idle with ready high
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_ff <= PSRFW_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // capture fields when a recognised word is taken;
  // a word turned away leaves the last fields showing
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      dest_ff <= 1'b0;
      cond_ff <= COND_RST;
      idx_ff <= IDX_RST;
    end else if (take_rec) begin
      cond_ff <= i_instr[COND_HI:COND_LO];
      dest_ff <= i_instr[DEST_SEL_BIT];
      idx_ff <= i_instr[SRC_IDX_HI:0];
    end
  end

  // source value: rotated immediate at take, register data during fetch;
  // register data is taken in the one cycle the read request stands
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      src_ff <= WORD_RST;
    end else if (take_rec && is_imm) begin
      src_ff <= rot_imm(i_instr[IMM8_HI:0], i_instr[ROT_HI:ROT_LO]);
    end else if (state_ff == PSRFW_FETCH) begin
      src_ff <= i_src_reg_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // read request: one cycle, launched as the register-form word is taken,
  // so the register file answers in the fetch cycle
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_src_reg_rd <= 1'b0;
    end else begin
      o_src_reg_rd <= take_rec && !is_imm;
    end
  end

  // unrecognised pulse: one cycle per word turned away; nothing else moves
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_unrecognised <= 1'b0;
    end else begin
      o_unrecognised <= take_bad;
    end
  end

  // fields hold from one recognised word to the next
  assign o_source_reg_index = idx_ff;
  assign o_cond = cond_ff;
  assign o_dest_status_select = dest_ff;
  // the mask is fixed: this form never reaches the control bits
  assign o_wr_mask = FLAG_MASK;

  // write strobe: one cycle after the write state, whatever the operand
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_wr_en <= 1'b0;
    end else begin
      o_wr_en <= (state_ff == PSRFW_WRITE);
    end
  end

  // write data: status word sampled late so the merge sees the latest
  // value, including a write that landed on the edge this word was taken
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_wr_data <= WORD_RST;
    end else if (state_ff == PSRFW_WRITE) begin
      o_wr_data <= merge_flags(dest_ff ? i_saved_status_reg : i_current_status_reg, src_ff);
    end
  end
endmodule

// ===== testbench/psrfw_assertions.sv
`timescale 1ns/1ps
module psrfw_checker (
  input wire logic i_core_clk, i_srst, i_instr_valid, o_instr_ready, o_src_reg_rd, o_wr_en, // strobes
  input wire logic o_dest_status_select, o_unrecognised, // results
  input wire logic [3:0] o_source_reg_index, o_cond, // fields
  input wire logic [31:0] i_instr, i_src_reg_data, i_current_status_reg, i_saved_status_reg, // words in
  input wire logic [31:0] o_wr_data, o_wr_mask // write out
);
  // take and match worked out here, not borrowed from the design
  wire tk = i_instr_valid & o_instr_ready;
  wire ok = tk && i_instr[27:26] == 2'h0 && i_instr[24:23] == 2'h2 && i_instr[21:12] == 10'h14f
    && (i_instr[25] || i_instr[11:4] == 8'h00);
  wire [31:0] b = {24'h00_0000, i_instr[7:0]};
  wire [31:0] rot = (b >> (2 * i_instr[11:8])) | (b << (32 - 2 * i_instr[11:8]));
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  a_cond_field: assert property (ok |-> ##2 o_cond == $past(i_instr[31:28], 2)) else $error("cond");
  a_dest_select: assert property (ok |-> ##2 o_dest_status_select == $past(i_instr[22], 2)) else $error("dest");
  a_imm_write: assert property (
    ok && i_instr[25] |-> ##2 o_wr_en && o_wr_data[31:28] == $past(rot[31:28], 2)) else $error("imm");
  a_reg_fetch: assert property (
    ok && !i_instr[25] |=> o_src_reg_rd && o_source_reg_index == $past(i_instr[3:0])) else $error("fetch");
  a_reg_data: assert property (
    o_src_reg_rd |-> ##2 o_wr_en && o_wr_data[31:28] == $past(i_src_reg_data[31:28], 2)) else $error("reg");
  a_flags_only: assert property (o_wr_en |-> o_wr_data[27:0] ==
    (o_dest_status_select ? i_saved_status_reg[27:0] : i_current_status_reg[27:0])) else $error("keep");
  // a recognised word closes the door until its write goes out
  a_busy_ready: assert property (ok |=> !o_instr_ready) else $error("busy");
  a_mask_flags: assert property (o_wr_en |-> o_wr_mask == 32'hf000_0000) else $error("mask");
  a_pattern_check: assert property (tk |=> o_unrecognised != $past(ok)) else $error("match");
  // two quiet cycles only: a following word may legally write on the third
  a_reject_quiet: assert property (tk && !ok |=> !o_wr_en [*2]) else $error("wrote");
  c_imm: cover property (ok && i_instr[25]);
  c_reg: cover property (ok && !i_instr[25]);
  c_bad: cover property (tk && !ok);
  c_saved: cover property (o_wr_en && o_dest_status_select);
endmodule
bind psrfw_decoder psrfw_checker i_chk (.*);

// ===== testbench/psrfw_status_file.sv
`timescale 1ns/1ps
module psrfw_status_file (
  input wire logic i_core_clk, o_src_reg_rd, o_wr_en, o_dest_status_select, // from decoder
  input wire logic [3:0] o_source_reg_index, // register asked for
  input wire logic [31:0] o_wr_data, o_wr_mask, // status write
  output logic [31:0] i_src_reg_data, i_current_status_reg = 32'h0123_4567, i_saved_status_reg = 32'h89ab_cdef // out
);
  // flags follow the index; outside the read the inverse shows, so a late sample is caught
  wire [31:0] v = {o_source_reg_index, 28'h5a5_c3e1};
  assign i_src_reg_data = o_src_reg_rd ? v : ~v;
  // only masked bits change, on the strobe
  always @(posedge i_core_clk) begin
    if (o_wr_en) begin
      if (o_dest_status_select) i_saved_status_reg <= (i_saved_status_reg & ~o_wr_mask) | (o_wr_data & o_wr_mask);
      else i_current_status_reg <= (i_current_status_reg & ~o_wr_mask) | (o_wr_data & o_wr_mask);
    end
  end
endmodule

// ===== testbench/psr_flag_write_decoder_tb.sv
`timescale 1ns/1ps
module psr_flag_write_decoder_tb;
  logic i_core_clk = 0, i_srst = 1, i_instr_valid = 0, o_instr_ready, o_src_reg_rd, o_wr_en;
  logic o_dest_status_select, o_unrecognised;
  logic [3:0] o_source_reg_index, o_cond;
  logic [31:0] i_instr = 0, i_src_reg_data, i_current_status_reg, i_saved_status_reg, o_wr_data, o_wr_mask;
  logic [31:0] cu = 32'h0123_4567, sv = 32'h89ab_cdef, w, e, r;
  int fail_count = 0, checks = 0;
  logic hung = 0;
  always #4 i_core_clk = ~i_core_clk;
  psrfw_decoder i_dut (.*);
  psrfw_status_file i_far (.*);
  task automatic chk(input logic t, input string m);
    checks++;
    if (!t) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one word in, model the answer, wait a bounded time for the write strobe or the unrecognised pulse
  task automatic send(input logic [31:0] x);
    logic ok, hit;
    ok = x[27:26] == 2'h0 && x[24:23] == 2'h2 && x[21:12] == 10'h14f && (x[25] || x[11:4] == 8'h00);
    r = {24'h00_0000, x[7:0]};
    r = (r >> (2 * x[11:8])) | (r << (32 - 2 * x[11:8]));
    e = x[22] ? sv : cu;
    e[31:28] = x[25] ? r[31:28] : x[3:0];
    i_instr_valid = 1;
    i_instr = x;
    @(posedge i_core_clk) #1;
    i_instr_valid = 0;
    hit = 0;
    for (int n = 0; n < 6 && !hit; n++) begin
      hit = ok ? o_wr_en === 1'b1 : o_unrecognised === 1'b1;
      if (!hit) @(posedge i_core_clk) #1;
    end
    chk(hit, "no answer");
    // a hung decoder ends the scenario loop; the verdict then reports it
    if (!hit) hung = 1;
    if (ok && hit) chk(o_wr_data === e, "write data");
    if (ok && hit) chk(o_cond === x[31:28], "condition");
    if (ok && hit) chk(o_dest_status_select === x[22], "destination");
    if (ok && hit) chk(o_wr_mask === 32'hf000_0000, "mask");
    if (ok && hit && x[22]) sv = e;
    else if (ok && hit) cu = e;
  endtask
  initial begin
    w = $urandom(32'h66a2);
    repeat (2) @(posedge i_core_clk);
    #1 i_srst = 0;
    for (int k = 0; k < 300 && !hung; k++) begin
      w = $urandom;
      w[27:12] = {2'h0, w[25], 2'h2, w[22], 10'h14f};
      if (!w[25]) w[11:4] = 8'h00;
      // stray bits in the fixed fields or the select bits 22 and 25, and in the zero field of the register form
      if (k % 7 == 0) w[27:12] = w[27:12] ^ (16'h0001 << (k % 16));
      if (k % 11 == 0) w[11:4] = w[11:4] ^ 8'h10;
      send(w);
    end
    give_verdict();
  end
endmodule
